// >>> inc/kbe_map.svh
`ifndef KBE_MAP_SVH
`define KBE_MAP_SVH

// memory-mapped offsets inside the operational register space
`define KBE_OFS_INPUT      12'h104
`define KBE_OFS_OUTPUT     12'h108
`define KBE_OFS_STATUS     12'h10C

// legacy keyboard controller I/O ports
`define KBE_PORT_DATA      16'h0060
`define KBE_PORT_CMD       16'h0064

// command byte that opens a gate A20 sequence
`define KBE_CMD_GATE_A20   8'hD1

// status bit positions
`define KBE_ST_OUT_FULL    0
`define KBE_ST_IN_FULL     1
`define KBE_ST_FLAG        2
`define KBE_ST_CMD_DATA    3
`define KBE_ST_INHIBIT     4
`define KBE_ST_AUX_FULL    5
`define KBE_ST_TIMEOUT     6
`define KBE_ST_PARITY      7

// data bit inside a gate A20 data write that carries the new gate level
`define KBE_A20_DATA_BIT   1

// reset values
`define KBE_RST_INPUT      32'h0000_0000
`define KBE_RST_OUTPUT     32'h0000_0000
`define KBE_RST_STATUS     32'h0000_0000

`endif

// >>> inc/kbe_pkg.sv
package kbe_pkg;

    // one I/O port cycle from the legacy side, held for one clock
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] port;
        logic [7:0]  data;
    } kbe_io_req_type;

    // one memory cycle from the emulation software side, held for one clock
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } kbe_mem_req_type;

    // control bits kept in the emulation control register outside this block
    typedef struct packed {
        logic emulationEnableBit;
        logic irqGenerateEnable;
        logic charPending;
    } kbe_ctrl_type;

    typedef struct packed {
        logic keyboardIrqLine;
        logic mouseIrqLine;
        logic emulationIrq;
    } kbe_irq_type;

    typedef struct packed {
        logic parity;
        logic timeout;
        logic auxOutFull;
        logic keyboardInhibitState;
        logic cmdData;
        logic flag;
        logic inFull;
        logic outFull;
    } kbe_status_type;

    typedef struct packed {
        logic [31:0]    inputWord;
        logic [31:0]    outputWord;
        logic [23:0]    statusUpper;
        kbe_status_type status;
        logic           gateA20Sequence;
        logic           gateA20State;
        logic           inhibitSeen;
        logic           ioAck;
        logic [7:0]     ioRdata;
        logic           ioHit;
        logic           memAck;
        logic [31:0]    memRdata;
        logic           memErr;
        kbe_irq_type    irq;
    } kbe_state_type;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } kbe_sync_state_type;

endpackage

// >>> rtl/kbe_sync.sv
`timescale 1ns/1ps

module kbe_sync (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic asyncIn,
    output logic      syncOut
);

    kbe_pkg::kbe_sync_state_type state;
    kbe_pkg::kbe_sync_state_type next_state;

    // first stage is read only by the second stage
    always_comb begin
        next_state        = state;
        next_state.stage1 = asyncIn;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign syncOut = state.stage2;

endmodule

// >>> rtl/kbe_regs.sv
`timescale 1ns/1ps
`include "kbe_map.svh"

// Function
// - capture port 60h/64h writes when enabled
// - memory access of input byte, no effects
// - port 60h read returns output byte
// - port 60h read clears output-full
// - port 64h read returns status
// - memory access of status, no effects
// - command/data flag: 60h clears, 64h sets
// - writes set input-full except A20 sequence
// - input-full plus enable raises emulation interrupt
// - output empty plus pending raises interrupt
// - mouse IRQ on aux, full, enable
// - aux flag selects which IRQ line
// - bytes sit in bits 7 to 0
// - parity, timeout and boot flag status bits
// - inhibit bit high means keyboard active
// - D1h to 64h sets A20 sequence
// - keyboard IRQ when aux clear, mouse otherwise
// - port decode and IRQs only when enabled, except the output-empty plus pending emulation interrupt
module kbe_regs (
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    input  wire kbe_pkg::kbe_io_req_type  ioReq,
    output logic                         ioHit,
    output logic                         ioAck,
    output logic [7:0]                   ioRdata,
    input  wire kbe_pkg::kbe_mem_req_type memReq,
    output logic                         memAck,
    output logic                         memErr,
    output logic [31:0]                  memRdata,
    input  wire kbe_pkg::kbe_ctrl_type    ctrl,
    input  wire logic                    keyboardInhibitPin,
    output logic                         gateA20Sequence,
    output logic                         gateA20State,
    output kbe_pkg::kbe_irq_type          irq
);

    kbe_pkg::kbe_state_type state;
    kbe_pkg::kbe_state_type next_state;

    logic inhibitSync;

    logic ioWrData;
    logic ioWrCmd;
    logic ioRdData;
    logic ioRdCmd;
    logic ioClaim;
    logic a20Cmd;
    logic a20DataWrite;
    logic memWrIn;
    logic memWrOut;
    logic memWrStatus;
    logic memMapped;

    kbe_sync u_inhibit_sync (
        .mclk    (mclk),
        .resetn  (resetn),
        .asyncIn (keyboardInhibitPin),
        .syncOut (inhibitSync)
    );

    function automatic logic portMatch(
        input kbe_pkg::kbe_io_req_type req,
        input logic [15:0]             port,
        input logic                    enable
    );
        portMatch = enable && (req.port == port);
    endfunction

    function automatic logic [31:0] statusWord(
        input logic [23:0]             upper,
        input kbe_pkg::kbe_status_type st
    );
        statusWord = {upper, st};
    endfunction

    // pick the legacy IRQ line from aux and output-full
    function automatic kbe_pkg::kbe_irq_type irqFrom(
        input kbe_pkg::kbe_status_type st,
        input kbe_pkg::kbe_ctrl_type   c
    );
        logic legacyOn;
        legacyOn                = c.emulationEnableBit && c.irqGenerateEnable && st.outFull;
        irqFrom.keyboardIrqLine = legacyOn && !st.auxOutFull;
        irqFrom.mouseIrqLine    = legacyOn && st.auxOutFull;
        irqFrom.emulationIrq    = (st.inFull && c.emulationEnableBit)
                                  || (!st.outFull && c.charPending);
    endfunction

    // port decode
    always_comb begin
        ioWrData = ioReq.wr && portMatch(ioReq, `KBE_PORT_DATA, ctrl.emulationEnableBit);
        ioWrCmd  = ioReq.wr && portMatch(ioReq, `KBE_PORT_CMD, ctrl.emulationEnableBit);
        ioRdData = ioReq.rd && portMatch(ioReq, `KBE_PORT_DATA, ctrl.emulationEnableBit);
        ioRdCmd  = ioReq.rd && portMatch(ioReq, `KBE_PORT_CMD, ctrl.emulationEnableBit);
        ioClaim  = ioWrData || ioWrCmd || ioRdData || ioRdCmd;
    end

    // gate A20 sequence detection
    always_comb begin
        a20Cmd       = ioWrCmd && (ioReq.data == `KBE_CMD_GATE_A20);
        a20DataWrite = ioWrData && state.gateA20Sequence;
    end

    // memory decode
    always_comb begin
        memWrIn     = 1'b0;
        memWrOut    = 1'b0;
        memWrStatus = 1'b0;
        memMapped   = 1'b1;
        if (memReq.addr == `KBE_OFS_INPUT) begin
            memWrIn = memReq.sel && memReq.wr;
        end else if (memReq.addr == `KBE_OFS_OUTPUT) begin
            memWrOut = memReq.sel && memReq.wr;
        end else if (memReq.addr == `KBE_OFS_STATUS) begin
            memWrStatus = memReq.sel && memReq.wr;
        end else begin
            memMapped = 1'b0;
        end
    end

    always_comb begin
        next_state = state;

        // software stores come first, so a same-cycle port event wins over them
        // plain store, no flag change
        if (memWrIn) begin
            next_state.inputWord = memReq.wdata;
        end
        if (memWrOut) begin
            next_state.outputWord = memReq.wdata;
        end
        // plain store of the status word
        if (memWrStatus) begin
            next_state.statusUpper = memReq.wdata[31:8];
            next_state.status      = kbe_pkg::kbe_status_type'(memReq.wdata[7:0]);
        end

        // switch follows the pin on each change only, so software may still overwrite it
        next_state.inhibitSeen = inhibitSync;
        if (inhibitSync != state.inhibitSeen) begin
            next_state.status.keyboardInhibitState = inhibitSync;
        end

        // byte in bits 7 to 0
        if (ioWrData || ioWrCmd) begin
            next_state.inputWord = {24'h00_0000, ioReq.data};
        end

        if (ioWrData) begin
            next_state.status.cmdData = 1'b0;
        end else if (ioWrCmd) begin
            next_state.status.cmdData = 1'b1;
        end

        // sequence bit from the command byte
        if (ioWrCmd) begin
            next_state.gateA20Sequence = a20Cmd;
        end
        if (a20DataWrite) begin
            next_state.gateA20State = ioReq.data[`KBE_A20_DATA_BIT];
        end

        if ((ioWrData && !a20DataWrite) || (ioWrCmd && !a20Cmd)) begin
            next_state.status.inFull = 1'b1;
        end

        if (ioRdData) begin
            next_state.status.outFull = 1'b0;
        end

        // I/O read answer, one cycle after the request
        next_state.ioAck   = ioRdData || ioRdCmd;
        next_state.ioHit   = ioClaim;
        next_state.ioRdata = state.ioRdata;
        if (ioRdData) begin
            next_state.ioRdata = state.outputWord[7:0];
        end else if (ioRdCmd) begin
            next_state.ioRdata = state.status;
        end

        // memory read answer, one cycle after the request, without side effects
        next_state.memAck   = memReq.sel;
        next_state.memErr   = memReq.sel && !memMapped;
        next_state.memRdata = state.memRdata;
        if (memReq.sel && !memReq.wr) begin
            if (memReq.addr == `KBE_OFS_INPUT) begin
                next_state.memRdata = state.inputWord;
            end else if (memReq.addr == `KBE_OFS_OUTPUT) begin
                next_state.memRdata = state.outputWord;
            end else if (memReq.addr == `KBE_OFS_STATUS) begin
                next_state.memRdata = statusWord(state.statusUpper, state.status);
            end else begin
                next_state.memRdata = 32'h0000_0000;
            end
        end

        // irq follows the updated flags so lines settle in the same edge
        next_state.irq = irqFrom(next_state.status, ctrl);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state            <= '0;
            state.inputWord  <= `KBE_RST_INPUT;
            state.outputWord <= `KBE_RST_OUTPUT;
            state.status     <= kbe_pkg::kbe_status_type'(8'h00);
        end else begin
            state <= next_state;
        end
    end

    assign ioHit           = state.ioHit;
    assign ioAck           = state.ioAck;
    assign ioRdata         = state.ioRdata;
    assign memAck          = state.memAck;
    assign memErr          = state.memErr;
    assign memRdata        = state.memRdata;
    assign gateA20Sequence = state.gateA20Sequence;
    assign gateA20State    = state.gateA20State;
    assign irq             = state.irq;

endmodule

// >>> tb/kbe_regs_properties.sv
`timescale 1ns/1ps
`include "kbe_map.svh"
module kbe_regs_properties (
    input wire logic                     mclk,
    input wire logic                     resetn,
    input wire kbe_pkg::kbe_io_req_type  ioReq,
    input wire logic                     ioHit,
    input wire logic                     ioAck,
    input wire kbe_pkg::kbe_mem_req_type memReq,
    input wire logic                     memAck,
    input wire kbe_pkg::kbe_ctrl_type    ctrl,
    input wire logic                     gateA20Sequence,
    input wire kbe_pkg::kbe_irq_type     irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic emuOn, any, dec, w64, r60;
    assign emuOn = ctrl.emulationEnableBit;
    assign any   = ioReq.rd | ioReq.wr;
    assign dec   = any & emuOn
                   & ((ioReq.port == `KBE_PORT_DATA) | (ioReq.port == `KBE_PORT_CMD));
    assign w64   = ioReq.wr & emuOn & (ioReq.port == `KBE_PORT_CMD);
    assign r60   = ioReq.rd & emuOn & (ioReq.port == `KBE_PORT_DATA);
    property p_hit; dec |=> ioHit; endproperty
    a_hit: assert property (p_hit) else $error("no hit");
    property p_nohit; any && !emuOn |=> !ioHit; endproperty
    a_nohit: assert property (p_nohit) else $error("hit while off");
    property p_ack; r60 |=> ioAck; endproperty
    a_ack: assert property (p_ack) else $error("no read ack");
    property p_mem; memReq.sel |=> memAck; endproperty
    a_mem: assert property (p_mem) else $error("no mem ack");
    property p_a20set; w64 && ioReq.data == `KBE_CMD_GATE_A20 |=> gateA20Sequence; endproperty
    a_a20set: assert property (p_a20set) else $error("sequence not set");
    property p_a20clr; w64 && ioReq.data != `KBE_CMD_GATE_A20 |=> !gateA20Sequence; endproperty
    a_a20clr: assert property (p_a20clr) else $error("sequence kept");
    property p_emi;
        w64 && ioReq.data != `KBE_CMD_GATE_A20 ##1 emuOn && !memReq.sel |=> irq.emulationIrq;
    endproperty
    a_emi: assert property (p_emi) else $error("no emulation irq");
    property p_drop; r60 |=> !irq.keyboardIrqLine && !irq.mouseIrqLine; endproperty
    a_drop: assert property (p_drop) else $error("irq kept after read");
    property p_off; (!emuOn) [*4] |-> !irq.keyboardIrqLine && !irq.mouseIrqLine; endproperty
    a_off: assert property (p_off) else $error("irq while off");
    property p_one; !(irq.keyboardIrqLine && irq.mouseIrqLine); endproperty
    a_one: assert property (p_one) else $error("both irq lines");
endmodule

// >>> tb/kbe_legacy_host.sv
`timescale 1ns/1ps
module kbe_legacy_host (
    input  wire logic              mclk,
    input  wire logic [7:0]        ioRdata,
    output kbe_pkg::kbe_io_req_type ioReq
);
    initial ioReq = '0;
    task automatic cyc(input logic rd, input logic [15:0] p, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge mclk);
        #1 ioReq = {rd, ~rd, p, d};
        @(posedge mclk);
        #1 q = ioRdata;
        // released lines show the inverse, not the stale value
        ioReq = {2'b00, ~p, ~d};
    endtask
endmodule

// >>> tb/test_kbe_regs.sv
`timescale 1ns/1ps
`include "kbe_map.svh"
module test_kbe_regs;
    logic                     mclk = 0;
    logic                     resetn = 0;
    logic                     keyboardInhibitPin = 0;
    kbe_pkg::kbe_mem_req_type memReq = '0;
    kbe_pkg::kbe_ctrl_type    ctrl = '0;
    kbe_pkg::kbe_io_req_type  ioReq;
    kbe_pkg::kbe_irq_type     irq;
    logic                     ioHit, ioAck, memAck, memErr, gateA20Sequence, gateA20State;
    logic [7:0]               ioRdata, q8;
    logic [31:0]              memRdata, q;
    int                       bad_count = 0;
    int                       compares = 0;
    always #2.5 mclk = ~mclk;
    kbe_regs kbe_regs_i (.mclk(mclk), .resetn(resetn), .ioReq(ioReq), .ioHit(ioHit),
        .ioAck(ioAck), .ioRdata(ioRdata), .memReq(memReq), .memAck(memAck), .memErr(memErr),
        .memRdata(memRdata), .ctrl(ctrl), .keyboardInhibitPin(keyboardInhibitPin),
        .gateA20Sequence(gateA20Sequence), .gateA20State(gateA20State), .irq(irq));
    kbe_legacy_host kbe_legacy_host_i (.mclk(mclk), .ioRdata(ioRdata), .ioReq(ioReq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic mem(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        @(posedge mclk);
        #1 memReq = {1'b1, w, a, d};
        @(posedge mclk);
        #1 memReq.sel = 0;
        q = memRdata;
        chk({memAck, memErr}, {1'b1, e});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        mem(0, a, 0, 0);
        chk(q, e);
    endtask
    task automatic pw(input logic [15:0] p, input logic [7:0] d);
        kbe_legacy_host_i.cyc(0, p, d, q8);
    endtask
    task automatic pr(input logic [15:0] p);
        kbe_legacy_host_i.cyc(1, p, 0, q8);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic t_reset;
        rd(`KBE_OFS_INPUT, 0);
        rd(`KBE_OFS_OUTPUT, 0);
        rd(`KBE_OFS_STATUS, 0);
        mem(0, 12'h200, 0, 1);
        chk(q, 0);
        $display("reset test done");
    endtask
    task automatic t_write;
        ctrl = 3'b100;
        wt(2);
        pw(`KBE_PORT_DATA, 8'h5A);
        rd(`KBE_OFS_INPUT, 32'h5A);
        rd(`KBE_OFS_STATUS, 32'h02);
        pw(`KBE_PORT_CMD, 8'hAB);
        rd(`KBE_OFS_INPUT, 32'hAB);
        rd(`KBE_OFS_STATUS, 32'h0A);
        chk(irq.emulationIrq, 1);
        mem(1, `KBE_OFS_INPUT, 0, 0);
        rd(`KBE_OFS_STATUS, 32'h0A);
        mem(1, `KBE_OFS_STATUS, 32'hC4, 0);
        rd(`KBE_OFS_STATUS, 32'hC4);
        rd(`KBE_OFS_STATUS, 32'hC4);
        chk(irq.emulationIrq, 0);
        keyboardInhibitPin = 1;
        wt(4);
        rd(`KBE_OFS_STATUS, 32'hD4);
        $display("write test done");
    endtask
    task automatic t_out;
        ctrl = 3'b110;
        mem(1, `KBE_OFS_OUTPUT, 32'h3C, 0);
        mem(1, `KBE_OFS_STATUS, 32'h01, 0);
        wt(3);
        chk(irq, 3'b100);
        mem(1, `KBE_OFS_STATUS, 32'h21, 0);
        rd(`KBE_OFS_OUTPUT, 32'h3C);
        wt(3);
        chk(irq, 3'b010);
        ctrl.charPending = 1;
        pr(`KBE_PORT_DATA);
        chk(q8, 8'h3C);
        wt(3);
        chk(irq, 3'b001);
        rd(`KBE_OFS_STATUS, 32'h20);
        pr(`KBE_PORT_CMD);
        chk(q8, 8'h20);
        ctrl.charPending = 0;
        $display("output test done");
    endtask
    task automatic t_a20;
        ctrl = 3'b100;
        mem(1, `KBE_OFS_STATUS, 0, 0);
        pw(`KBE_PORT_CMD, `KBE_CMD_GATE_A20);
        chk(gateA20Sequence, 1);
        rd(`KBE_OFS_STATUS, 32'h08);
        pw(`KBE_PORT_DATA, 8'h02);
        chk(gateA20State, 1);
        rd(`KBE_OFS_STATUS, 0);
        pw(`KBE_PORT_CMD, 8'hFF);
        chk(gateA20Sequence, 0);
        rd(`KBE_OFS_STATUS, 32'h0A);
        $display("gate test done");
    endtask
    task automatic t_off;
        // irq enable, output-full and input-full on, aux clear, so the enable bit keeps the keyboard and emulation lines low
        ctrl = 3'b010;
        mem(1, `KBE_OFS_STATUS, 32'h0B, 0);
        wt(2);
        pw(`KBE_PORT_DATA, 8'h77);
        rd(`KBE_OFS_INPUT, 32'hFF);
        rd(`KBE_OFS_STATUS, 32'h0B);
        chk(irq[2:1], 0);
        chk(irq.emulationIrq, 0);
        $display("disable test done");
    endtask
    task automatic results;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        results;
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1 resetn = 1;
        t_reset;
        t_write;
        t_out;
        t_a20;
        t_off;
        results;
    end
endmodule
bind kbe_regs kbe_regs_properties kbe_regs_properties_i (.mclk(mclk), .resetn(resetn),
    .ioReq(ioReq), .ioHit(ioHit), .ioAck(ioAck), .memReq(memReq), .memAck(memAck),
    .ctrl(ctrl), .gateA20Sequence(gateA20Sequence), .irq(irq));
